// *** hdl/atrc_pkg.sv ***
// Package for the converter trigger-select and result-compare block.
// Assumes a 32-bit Avalon-MM register port with byte addresses.
package atrc_pkg;
	// Sizes
	localparam int ATRC_NUM_CH = 26;
	localparam int ATRC_NUM_CMP = 4;
	localparam int ATRC_NUM_TRIG_REGS = 13;
	localparam int ATRC_RES_W = 16;
	localparam int ATRC_READY_FIRST = 16;
	localparam int ATRC_READY_W = 10;

	// Byte offsets; each register takes one aligned word
	localparam logic [7:0] ATRC_OFS_READY_HIGH = 8'h00;
	localparam logic [7:0] ATRC_OFS_TRIG_BASE = 8'h04;
	localparam logic [7:0] ATRC_OFS_CMP_CTRL_BASE = 8'h40;
	localparam logic [7:0] ATRC_OFS_CMP_LO_BASE = 8'h50;
	localparam logic [7:0] ATRC_OFS_CMP_HI_BASE = 8'h60;
	localparam logic [7:0] ATRC_OFS_CMP_MASK_BASE = 8'h70;

	// Trigger select fields
	localparam int ATRC_TRG_W = 5;
	localparam int ATRC_TRG_EVEN_LSB = 0;
	localparam int ATRC_TRG_ODD_LSB = 8;
	localparam logic [4:0] ATRC_TRG_RST = 5'h00;

	// Trigger source codes
	localparam logic [4:0] ATRC_SEL_OFF = 5'h00;
	localparam logic [4:0] ATRC_SEL_SW_COMMON = 5'h01;
	localparam logic [4:0] ATRC_SEL_SW_LEVEL = 5'h02;
	localparam logic [4:0] ATRC_SEL_RESERVED = 5'h03;
	localparam logic [4:0] ATRC_SEL_PWM_FIRST = 5'h04;
	localparam logic [4:0] ATRC_SEL_PWM_LAST = 5'h13;
	localparam logic [4:0] ATRC_SEL_CCP_FIRST = 5'h14;
	localparam logic [4:0] ATRC_SEL_CCP_LAST = 5'h1b;
	localparam logic [4:0] ATRC_SEL_LOGIC_CELL_ONE_OUTPUT = 5'h1c;
	localparam logic [4:0] ATRC_SEL_LOGIC_CELL_TWO_OUTPUT = 5'h1d;
	localparam logic [4:0] ATRC_SEL_SEQ = 5'h1e;
	localparam logic [4:0] ATRC_SEL_EXT_PIN = 5'h1f;

	// Comparator control fields
	localparam int ATRC_CMP_EN_BIT = 7;
	localparam int ATRC_CMP_IE_BIT = 6;
	localparam int ATRC_CMP_STAT_BIT = 5;
	localparam int ATRC_CMP_BETWEEN_LIMITS_CONDITION_BIT = 4;
	localparam int ATRC_CMP_HIGH_ABOVE_CONDITION_BIT = 3;
	localparam int ATRC_CMP_HIGH_BELOW_CONDITION_BIT = 2;
	localparam int ATRC_CMP_LOW_ABOVE_CONDITION_BIT = 1;
	localparam int ATRC_CMP_LOW_BELOW_CONDITION_BIT = 0;
	localparam int ATRC_CMP_EVENT_CHANNEL_NUMBER_LSB = 8;
	localparam logic [7:0] ATRC_CMP_CTRL_WMASK = 8'hdf;
	localparam logic [7:0] ATRC_CMP_CTRL_RST = 8'h00;
	localparam logic [4:0] ATRC_EVENT_CHANNEL_NUMBER_RST = 5'h00;
	localparam logic [15:0] ATRC_THRESH_RST = 16'h0000;
	localparam logic [25:0] ATRC_MASK_RST = 26'h0000000;

	// One stored conversion result from the converter core
	typedef struct packed {
		logic valid;
		logic [4:0] channel;
		logic [15:0] data;
	} atrc_result_t;

	// Trigger sources from the on-chip peripherals
	typedef struct packed {
		logic sw_common;
		logic sw_level;
		logic [15:0] pwm;
		logic [7:0] ccp;
		logic logic_cell_one_output;
		logic logic_cell_two_output;
		logic seq;
		logic ext_pin;
	} atrc_trig_src_t;
endpackage : atrc_pkg

// *** hdl/atrc_top.sv ***
// Trigger-source selection per channel and four digital result comparators.
// Assumes one clock, synchronous inputs, a converter core that reports each
// stored result as a one-cycle valid and keeps its own ready flags.
//
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps

// Behaviour
// - Ready flags 16..25 read-only, upper bits zero
// - Five-bit selector per channel, packed two per register
// - Codes 0 off, 1 common, 2 level, 3 reserved
// - Codes 4..19 pick PWM triggers in pairs
// - Codes 20..27 pick capture/compare units 1-7, 9
// - Codes 28..31 logic cells, sequencer, external pin
// - Channel c lives in register c/2, even low
// - Unused selector bits ignore writes, read zero
// - Clearing comparator enable also clears event flag
// - Event records causing channel number in bits 12:8
// - Interrupt enable routes event to common interrupt
// - Event flag set by hardware, cleared on read
// - Between: low <= result < high
// - High-above: result >= high
// - High-below: result < high
// - Low-above: result >= low
// - Low-below: result < low
// - Only masked-in channels reach a comparator
module atrc_top
	import atrc_pkg::*;
#(
	parameter int NUM_CH = ATRC_NUM_CH,
	parameter int NUM_CMP = ATRC_NUM_CMP
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [NUM_CH-1:0] channel_result_ready_flags,
	input wire atrc_result_t channel_result_buffer,
	input wire atrc_trig_src_t trig_src,
	output logic [NUM_CH-1:0] conv_start_reg,
	output logic common_irq_reg,
	output logic [NUM_CMP-1:0] cmp_irq_reg
);
	// Register storage
	logic [4:0] channel_trigger_source [NUM_CH];
	logic [7:0] cmp_ctrl_reg [NUM_CMP];
	logic [4:0] event_channel_number [NUM_CMP];
	logic [15:0] compare_low_threshold [NUM_CMP];
	logic [15:0] compare_high_threshold [NUM_CMP];
	logic [NUM_CH-1:0] cmp_mask_reg [NUM_CMP];

	// Bus access qualifiers
	logic commit;
	logic wr_commit;
	logic rd_commit;
	logic [5:0] word_idx;
	logic [31:0] rdata_next;
	logic [31:0] src_vec;
	logic [NUM_CMP-1:0] cmp_hit;
	logic [NUM_CMP-1:0] event_channel_number_read;
	logic [NUM_CMP-1:0] ctrl_wr;

	// Waitrequest drops one cycle after a request appears; the access
	// completes on the edge that samples it low, so side effects fire once.
	assign commit = (avs_read | avs_write) & ~avs_waitrequest;
	assign wr_commit = commit & avs_write;
	assign rd_commit = commit & avs_read;
	assign word_idx = avs_address[7:2];

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
		end else if (ce) begin
			if (commit) begin
				avs_waitrequest <= 1'b1;
			end else if (avs_read | avs_write) begin
				avs_waitrequest <= 1'b0;
			end
		end
	end

	// Read data is captured when waitrequest falls and holds until the next
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			avs_readdata <= 32'h00000000;
		end else if (ce) begin
			if (avs_read & avs_waitrequest) begin
				avs_readdata <= rdata_next;
			end
		end
	end

	// Read mux; unmapped words read zero
	always_comb begin
		rdata_next = 32'h00000000;
		if (avs_address[7:2] == ATRC_OFS_READY_HIGH[7:2]) begin
			rdata_next[ATRC_READY_W-1:0] =
				channel_result_ready_flags[ATRC_READY_FIRST +: ATRC_READY_W];
		end
		for (int k = 0; k < ATRC_NUM_TRIG_REGS; k++) begin
			if (word_idx == 6'(ATRC_OFS_TRIG_BASE[7:2] + 6'(k))) begin
				rdata_next[ATRC_TRG_EVEN_LSB +: ATRC_TRG_W] =
					channel_trigger_source[2*k];
				rdata_next[ATRC_TRG_ODD_LSB +: ATRC_TRG_W] =
					channel_trigger_source[2*k+1];
			end
		end
		for (int x = 0; x < NUM_CMP; x++) begin
			if (word_idx == 6'(ATRC_OFS_CMP_CTRL_BASE[7:2] + 6'(x))) begin
				rdata_next[7:0] = cmp_ctrl_reg[x];
				rdata_next[ATRC_CMP_EVENT_CHANNEL_NUMBER_LSB +: 5] = event_channel_number[x];
			end
			if (word_idx == 6'(ATRC_OFS_CMP_LO_BASE[7:2] + 6'(x))) begin
				rdata_next[15:0] = compare_low_threshold[x];
			end
			if (word_idx == 6'(ATRC_OFS_CMP_HI_BASE[7:2] + 6'(x))) begin
				rdata_next[15:0] = compare_high_threshold[x];
			end
			if (word_idx == 6'(ATRC_OFS_CMP_MASK_BASE[7:2] + 6'(x))) begin
				rdata_next[NUM_CH-1:0] = cmp_mask_reg[x];
			end
		end
	end

	// Trigger selectors; only the five implemented bits of each byte store
	genvar gc;
	generate
		for (gc = 0; gc < NUM_CH; gc++) begin : g_trig
			localparam logic [5:0] WIDX = 6'(ATRC_OFS_TRIG_BASE[7:2] + 6'(gc / 2));
			localparam int BYTE = gc % 2; // Even channel low byte, odd high
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					channel_trigger_source[gc] <= ATRC_TRG_RST;
				end else if (ce) begin
					if (wr_commit && word_idx == WIDX && avs_byteenable[BYTE]) begin
						channel_trigger_source[gc] <=
							avs_writedata[8*BYTE +: ATRC_TRG_W];
					end
				end
			end

			// Start is the selected source, registered once per cycle
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					conv_start_reg[gc] <= 1'b0;
				end else if (ce) begin
					conv_start_reg[gc] <= src_vec[channel_trigger_source[gc]];
				end
			end
		end
	endgenerate

	// Source vector indexed by selector code
	always_comb begin
		src_vec = 32'h00000000;
		src_vec[ATRC_SEL_OFF] = 1'b0;
		src_vec[ATRC_SEL_SW_COMMON] = trig_src.sw_common;
		src_vec[ATRC_SEL_SW_LEVEL] = trig_src.sw_level;
		src_vec[ATRC_SEL_RESERVED] = 1'b0; // Reserved never starts
		src_vec[ATRC_SEL_PWM_LAST:ATRC_SEL_PWM_FIRST] = trig_src.pwm;
		src_vec[ATRC_SEL_CCP_LAST:ATRC_SEL_CCP_FIRST] = trig_src.ccp;
		src_vec[ATRC_SEL_LOGIC_CELL_ONE_OUTPUT] = trig_src.logic_cell_one_output;
		src_vec[ATRC_SEL_LOGIC_CELL_TWO_OUTPUT] = trig_src.logic_cell_two_output;
		src_vec[ATRC_SEL_SEQ] = trig_src.seq;
		src_vec[ATRC_SEL_EXT_PIN] = trig_src.ext_pin;
	end

	// Digital comparators
	genvar gx;
	generate
		for (gx = 0; gx < NUM_CMP; gx++) begin : g_cmp
			localparam logic [5:0] CIDX = 6'(ATRC_OFS_CMP_CTRL_BASE[7:2] + 6'(gx));
			localparam logic [5:0] LIDX = 6'(ATRC_OFS_CMP_LO_BASE[7:2] + 6'(gx));
			localparam logic [5:0] HIDX = 6'(ATRC_OFS_CMP_HI_BASE[7:2] + 6'(gx));
			localparam logic [5:0] MIDX = 6'(ATRC_OFS_CMP_MASK_BASE[7:2] + 6'(gx));
			logic ge_lo;
			logic lt_hi;
			logic in_mask;
			logic [7:0] ctl;

			assign ctl = cmp_ctrl_reg[gx];
			assign ge_lo = channel_result_buffer.data >= compare_low_threshold[gx];
			assign lt_hi = channel_result_buffer.data < compare_high_threshold[gx];
			// Channel codes above the last input never match
			assign in_mask = (channel_result_buffer.channel < 5'(NUM_CH)) &&
				cmp_mask_reg[gx][channel_result_buffer.channel];
			// One check per valid result; conditions are ORed
			assign cmp_hit[gx] = channel_result_buffer.valid && in_mask &&
				ctl[ATRC_CMP_EN_BIT] && (
				(ctl[ATRC_CMP_BETWEEN_LIMITS_CONDITION_BIT] && ge_lo && lt_hi) ||
				(ctl[ATRC_CMP_HIGH_ABOVE_CONDITION_BIT] && !lt_hi) ||
				(ctl[ATRC_CMP_HIGH_BELOW_CONDITION_BIT] && lt_hi) ||
				(ctl[ATRC_CMP_LOW_ABOVE_CONDITION_BIT] && ge_lo) ||
				(ctl[ATRC_CMP_LOW_BELOW_CONDITION_BIT] && !ge_lo));
			assign ctrl_wr[gx] = wr_commit && word_idx == CIDX && avs_byteenable[0];
			assign event_channel_number_read[gx] = rd_commit && word_idx == CIDX;

			// Writable control bits; the status bit is hardware-owned
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					cmp_ctrl_reg[gx] <= ATRC_CMP_CTRL_RST;
				end else if (ce) begin
					if (cmp_hit[gx]) begin
						cmp_ctrl_reg[gx][ATRC_CMP_STAT_BIT] <= 1'b1; // Set wins
					end else if (ctrl_wr[gx] && !avs_writedata[ATRC_CMP_EN_BIT]) begin
						cmp_ctrl_reg[gx][ATRC_CMP_STAT_BIT] <= 1'b0;
					end else if (event_channel_number_read[gx]) begin
						cmp_ctrl_reg[gx][ATRC_CMP_STAT_BIT] <= 1'b0;
					end
					if (ctrl_wr[gx]) begin
						for (int b = 0; b < 8; b++) begin
							if (ATRC_CMP_CTRL_WMASK[b]) begin
								cmp_ctrl_reg[gx][b] <= avs_writedata[b];
							end
						end
					end
				end
			end

			// Channel that caused the latest event; read-only to software
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					event_channel_number[gx] <= ATRC_EVENT_CHANNEL_NUMBER_RST;
				end else if (ce) begin
					if (cmp_hit[gx]) begin
						event_channel_number[gx] <= channel_result_buffer.channel;
					end
				end
			end

			// Thresholds and channel mask
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					compare_low_threshold[gx] <= ATRC_THRESH_RST;
					compare_high_threshold[gx] <= ATRC_THRESH_RST;
					cmp_mask_reg[gx] <= ATRC_MASK_RST;
				end else if (ce && wr_commit) begin
					for (int b = 0; b < 4; b++) begin
						if (avs_byteenable[b]) begin
							if (b < 2 && word_idx == LIDX) begin
								compare_low_threshold[gx][8*(b%2) +: 8] <= avs_writedata[8*b +: 8];
							end
							if (b < 2 && word_idx == HIDX) begin
								compare_high_threshold[gx][8*(b%2) +: 8] <= avs_writedata[8*b +: 8];
							end
						end
					end
					if (word_idx == MIDX) begin
						for (int i = 0; i < NUM_CH; i++) begin
							if (avs_byteenable[i/8]) begin
								cmp_mask_reg[gx][i] <= avs_writedata[i];
							end
						end
					end
				end
			end

			// Event pulse goes to the common or the dedicated interrupt
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					cmp_irq_reg[gx] <= 1'b0;
				end else if (ce) begin
					cmp_irq_reg[gx] <= cmp_hit[gx] && !ctl[ATRC_CMP_IE_BIT];
				end
			end
		end
	endgenerate

	// Common interrupt pulse from any comparator with its interrupt enable set
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			common_irq_reg <= 1'b0;
		end else if (ce) begin
			common_irq_reg <= 1'b0;
			for (int x = 0; x < NUM_CMP; x++) begin
				if (cmp_hit[x] && cmp_ctrl_reg[x][ATRC_CMP_IE_BIT]) begin
					common_irq_reg <= 1'b1;
				end
			end
		end
	end
endmodule : atrc_top

// *** test/atrc_core_model.sv ***
// Converter core model: stores one result per request.
// Assumes the bench pulses req with channel and data.
`timescale 1ns/1ps
module atrc_core_model
	import atrc_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic req,
	input wire logic [4:0] ch,
	input wire logic [15:0] data,
	output atrc_result_t res,
	output logic [25:0] ready
);
	// One-cycle valid; idle fields invert so stale data never looks fresh
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			res <= '0;
		end else if (req) begin
			res <= '{1'b1, ch, data};
		end else begin
			res <= '{1'b0, ~res.channel, ~res.data};
		end
	end
	// Ready flag of a stored channel stays up
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ready <= '0;
		end else if (req && ch < 5'd26) begin
			ready[ch] <= 1'b1;
		end
	end
endmodule : atrc_core_model

// *** test/atrc_top_sva.sv ***
// Port checker for the trigger-select and compare block.
// Assumes ce high and one word per register.
`timescale 1ns/1ps
module atrc_top_sva
	import atrc_pkg::*;
#(
	parameter int NUM_CH = ATRC_NUM_CH,
	parameter int NUM_CMP = ATRC_NUM_CMP
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [NUM_CH-1:0] channel_result_ready_flags,
	input wire atrc_result_t channel_result_buffer,
	input wire atrc_trig_src_t trig_src,
	input wire logic [NUM_CH-1:0] conv_start_reg,
	input wire logic common_irq_reg,
	input wire logic [NUM_CMP-1:0] cmp_irq_reg
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic rd_done, res_v;
	logic [9:0] rdy_hi;
	// Read commit edge; helpers keep $past on plain signals
	assign rd_done = avs_read && !avs_waitrequest && ce;
	assign res_v = channel_result_buffer.valid;
	assign rdy_hi = channel_result_ready_flags[25:16];
	a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
		else $error("bus answer late");
	a_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_ready_upper: assert property (rd_done && avs_address[7:2] == 6'h00 |-> avs_readdata == {22'h0, $past(rdy_hi)})
		else $error("ready status wrong");
	a_trig_pad: assert property (rd_done && avs_address >= 8'h04 && avs_address < 8'h38 |-> avs_readdata[31:13] == '0 && avs_readdata[7:5] == '0)
		else $error("selector pad bits set");
	a_ctrl_pad: assert property (rd_done && avs_address[7:4] == 4'h4 |-> avs_readdata[31:13] == '0)
		else $error("control pad bits set");
	a_unmapped_zero: assert property (rd_done && avs_address >= 8'h80 |-> avs_readdata == '0)
		else $error("unmapped read not zero");
	a_irq_cause: assert property (|cmp_irq_reg || common_irq_reg |-> $past(res_v))
		else $error("interrupt without result");
	a_bad_chan: assert property (res_v && channel_result_buffer.channel >= 5'd26 |=> cmp_irq_reg == '0 && !common_irq_reg)
		else $error("bad channel raised event");
	a_idle_start: assert property (trig_src == '0 |=> conv_start_reg == '0)
		else $error("start without source");
	c_common: cover property (common_irq_reg);
	c_dedicated: cover property (cmp_irq_reg[0]);
	c_start: cover property (|conv_start_reg);
endmodule : atrc_top_sva
bind atrc_top atrc_top_sva #(.NUM_CH(NUM_CH), .NUM_CMP(NUM_CMP)) atrc_top_sva_inst (
	.clk(clk), .sys_rst(sys_rst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.channel_result_ready_flags(channel_result_ready_flags),
	.channel_result_buffer(channel_result_buffer), .trig_src(trig_src),
	.conv_start_reg(conv_start_reg), .common_irq_reg(common_irq_reg), .cmp_irq_reg(cmp_irq_reg));

// *** test/atrc_top_tb.sv ***
// Self-checking bench for the trigger-select and compare block.
// Assumes the core model feeds results; the bench owns the bus.
`timescale 1ns/1ps
module atrc_top_tb;
	import atrc_pkg::*;
	logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, avs_read = 1'b0, avs_write = 1'b0, req = 1'b0;
	logic [7:0] avs_address = '0;
	logic [31:0] avs_writedata = '0, avs_readdata, q;
	logic [3:0] avs_byteenable = 4'hf, cmp_irq_reg;
	logic avs_waitrequest, common_irq_reg;
	logic [4:0] ch = '0, exp_ch = '0;
	logic [15:0] data = '0;
	logic [25:0] ready, conv_start_reg;
	logic [29:0] v;
	atrc_result_t res;
	atrc_trig_src_t trig_src = '0;
	int n_fail = 0, samples_checked = 0, cyc = 0;
	// Write-then-read rows: {addr, wdata, readback}
	logic [39:0] regs [8] = '{{8'h04, 16'hffff, 16'h1f1f}, {8'h34, 16'h1d1c, 16'h1d1c},
		{8'h00, 16'hffff, 16'h03ff}, {8'hfc, 16'hffff, 16'h0000}, {8'h40, 16'hffff, 16'h00df},
		{8'h50, 16'h0100, 16'h0100}, {8'h60, 16'h0200, 16'h0200}, {8'h70, 16'h0020, 16'h0020}};
	// Compare rows: {ctrl, data, channel, event}; low 0x100, high 0x200, mask channel 5
	logic [29:0] cmps [12] = '{{8'h90, 16'h0100, 5'd5, 1'b1}, {8'h90, 16'h0200, 5'd5, 1'b0},
		{8'h88, 16'h0200, 5'd5, 1'b1}, {8'h88, 16'h01ff, 5'd5, 1'b0},
		{8'h84, 16'h01ff, 5'd5, 1'b1}, {8'h84, 16'h0200, 5'd5, 1'b0},
		{8'h82, 16'h0100, 5'd5, 1'b1}, {8'h82, 16'h00ff, 5'd5, 1'b0},
		{8'h81, 16'h00ff, 5'd5, 1'b1}, {8'h81, 16'h0100, 5'd5, 1'b0},
		{8'h9f, 16'h0300, 5'd6, 1'b0}, {8'hc8, 16'h0300, 5'd5, 1'b1}};
	atrc_top atrc_top_inst (.clk(clk), .sys_rst(sys_rst), .ce(ce), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .channel_result_ready_flags(ready),
		.channel_result_buffer(res), .trig_src(trig_src), .conv_start_reg(conv_start_reg),
		.common_irq_reg(common_irq_reg), .cmp_irq_reg(cmp_irq_reg));
	atrc_core_model atrc_core_model_inst (.clk(clk), .sys_rst(sys_rst), .req(req), .ch(ch),
		.data(data), .res(res), .ready(ready));
	// Clock and hang guard
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// Avalon access: hold until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {16'h0, d};
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	// One stored result; returns where the event outputs have settled
	task automatic send(input logic [4:0] c, input logic [15:0] d);
		@(posedge clk);
		req <= 1'b1;
		ch <= c;
		data <= d;
		@(posedge clk);
		req <= 1'b0;
		@(posedge clk);
		#1;
	endtask : send
	// Source vector bit that a selector code should follow
	function automatic logic [29:0] src_of(input logic [4:0] c);
		logic [29:0] s;
		s = '0;
		if (c == 5'd1) s[29] = 1'b1;
		else if (c == 5'd2) s[28] = 1'b1;
		else if (c >= 5'd4 && c <= 5'd19) s[c + 8] = 1'b1;
		else if (c >= 5'd20 && c <= 5'd27) s[c - 16] = 1'b1;
		else if (c >= 5'd28) s[31 - c] = 1'b1;
		return s;
	endfunction : src_of
	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		#1;
		chk({avs_waitrequest, common_irq_reg, cmp_irq_reg, conv_start_reg}, {1'b1, 31'h0});
		// Fill every ready flag, channels 26 and 27 included as strays
		for (int i = 0; i < 28; i++) begin
			send(5'(i), 16'h0);
		end
		chk({common_irq_reg, cmp_irq_reg}, '0);
		$display("reset and fill done");
		foreach (regs[i]) begin
			bus(1'b1, regs[i][39:32], regs[i][31:16]);
			bus(1'b0, regs[i][39:32], 16'h0);
			chk(q, {16'h0, regs[i][15:0]});
		end
		$display("register rows done");
		foreach (cmps[i]) begin
			bus(1'b1, 8'h40, {8'h0, cmps[i][29:22]});
			send(cmps[i][5:1], cmps[i][21:6]);
			chk({common_irq_reg, cmp_irq_reg}, {cmps[i][0] & cmps[i][28], 3'b0, cmps[i][0] & !cmps[i][28]});
			if (cmps[i][0]) exp_ch = cmps[i][5:1];
			bus(1'b0, 8'h40, 16'h0);
			chk(q, {19'h0, exp_ch, cmps[i][29:28], cmps[i][0], cmps[i][26:22]});
			bus(1'b0, 8'h40, 16'h0);
			chk(q[5], 1'b0);
		end
		// Disabling a comparator with an event pending drops its status
		bus(1'b1, 8'h40, 16'h0088);
		send(5'd5, 16'h0300);
		bus(1'b1, 8'h40, 16'h0008);
		bus(1'b0, 8'h40, 16'h0);
		chk(q, 32'h0508);
		$display("comparator rows done");
		// Every selector code on channels 0, 1, 24, 25: own source, then all others
		for (int c = 0; c < 32; c++) begin
			bus(1'b1, 8'h04, {3'b0, 5'(c), 3'b0, 5'(c)});
			bus(1'b1, 8'h34, {3'b0, 5'(c), 3'b0, 5'(c)});
			v = src_of(5'(c));
			for (int k = 0; k < 2; k++) begin
				@(posedge clk);
				trig_src <= atrc_trig_src_t'(k ? ~v : v);
				@(posedge clk);
				#1;
				chk({conv_start_reg[25:24], conv_start_reg[1:0]}, {4{k == 0 && c != 0 && c != 3}});
			end
			@(posedge clk);
			trig_src <= '0;
		end
		$display("trigger codes done");
		// Clock enable low must freeze the start outputs even with every source high
		@(posedge clk);
		ce <= 1'b0;
		trig_src <= '1;
		repeat (2) @(posedge clk);
		#1;
		chk(conv_start_reg, '0);
		@(posedge clk);
		ce <= 1'b1;
		trig_src <= '0;
		repeat (2) @(posedge clk);
		$display("clock enable done");
		// Mid-run reset returns the selectors to their reset code
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		bus(1'b0, 8'h04, 16'h0);
		chk(q, 32'h0);
		$display("mid-run reset done");
		tally_and_finish();
	end
endmodule : atrc_top_tb
